// *** hw/safety_cmd_classify.sv ***
// classifies one command byte: known read, protected write, unprotected write
// assumes a combinational use on the same clock as the decoder
`timescale 1ns/1ps
module safety_cmd_classify
(
    input  wire logic [7:0] code,
    output logic            is_protected_write,
    output logic            is_free_write,
    output logic            is_known_read
);

    // protected write set is the lock-guarded, state_a-only codes
    always_comb
    begin
        is_protected_write = 1'b0;
        is_free_write      = 1'b0;
        is_known_read      = 1'b0;
        case (code)
            safety_cmd_pkg::cmd_wd_count_write,
            safety_cmd_pkg::cmd_host_esm_count_write,
            safety_cmd_pkg::cmd_dev_err_count_write,
            safety_cmd_pkg::cmd_high_max_write,
            safety_cmd_pkg::cmd_high_min_write,
            safety_cmd_pkg::cmd_low_max_write,
            safety_cmd_pkg::cmd_low_min_write,
            safety_cmd_pkg::cmd_pwd_threshold_write,
            safety_cmd_pkg::cmd_config_crc_write:
                is_protected_write = 1'b1;
            safety_cmd_pkg::cmd_analog_selftest_write,
            safety_cmd_pkg::cmd_logic_selftest_write,
            safety_cmd_pkg::cmd_safety_check_write:
                is_free_write = 1'b1;
            safety_cmd_pkg::cmd_status_two_read,
            safety_cmd_pkg::cmd_status_three_read,
            safety_cmd_pkg::cmd_status_four_read,
            safety_cmd_pkg::cmd_high_max_read,
            safety_cmd_pkg::cmd_high_min_read,
            safety_cmd_pkg::cmd_low_max_read,
            safety_cmd_pkg::cmd_low_min_read,
            safety_cmd_pkg::cmd_pwd_threshold_read,
            safety_cmd_pkg::cmd_config_crc_read,
            safety_cmd_pkg::cmd_analog_selftest_read,
            safety_cmd_pkg::cmd_logic_selftest_read,
            safety_cmd_pkg::cmd_safety_check_read:
                is_known_read = 1'b1;
            default:
            begin
                is_protected_write = 1'b0;
                is_free_write      = 1'b0;
                is_known_read      = 1'b0;
            end
        endcase
    end

endmodule // safety_cmd_classify

// *** hw/spi_safety_command_decoder.sv ***
// decoder for the safety counter, pulse limit, power-down and crc commands
// assumes a frame engine on mclk presents code and data with a one-cycle cmd_valid pulse,
// and that lock and state_a-state levels come from logic on the same clock
//
// Function
// - write 0xa4 only in state_a changes just the watchdog failure count, read by 0x52.
// - write 0xa7 only in state_a changes just the host error-signal fail count, read by 0x54.
// - write 0xa8 only in state_a changes just the device error count, read by 0x57.
// - 0x91 writes the high pulse maximum under lock and state_a, 0x61 reads it.
// - 0x92 writes the high pulse minimum under lock and state_a, 0x62 reads it.
// - 0x94 writes the low pulse maximum under lock and state_a, 0x64 reads it.
// - 0x97 writes the low pulse minimum under lock and state_a, 0x67 reads it.
// - 0x98 writes the power-down threshold under lock and state_a, 0x68 reads it.
// - 0x9b writes the expected config crc under lock and state_a, 0x6b reads it.
// - protected writes are rejected while the host-set configuration lock is on.
`timescale 1ns/1ps
module spi_safety_command_decoder
(
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_code,
    input  wire logic [7:0] cmd_data,
    input  wire logic       config_lock,
    input  wire logic       state_a,
    input  wire logic [7:0] status_two_live,
    input  wire logic [7:0] status_three_live,
    input  wire logic [7:0] status_four_live,
    output logic            read_valid,
    output logic [7:0]      read_data,
    output logic            read_unknown,
    output logic            write_done,
    output logic            write_refused,
    output logic [3:0]      watchdog_failure_count,
    output logic [3:0]      host_error_signal_fail_count,
    output logic [3:0]      device_error_count,
    output logic [7:0]      error_high_pulse_max,
    output logic [7:0]      error_high_pulse_min,
    output logic [7:0]      error_low_pulse_max,
    output logic [7:0]      error_low_pulse_min,
    output logic [7:0]      power_down_threshold,
    output logic [7:0]      config_crc,
    output logic [7:0]      analog_selftest_control,
    output logic [7:0]      logic_selftest_control,
    output logic [7:0]      safety_check_control
);

    logic is_protected_write;
    logic is_free_write;
    logic is_known_read;
    logic write_allowed;

    safety_cmd_classify u_classify
    (
        .code               (cmd_code),
        .is_protected_write (is_protected_write),
        .is_free_write      (is_free_write),
        .is_known_read      (is_known_read)
    );

    // lock and state_a state both gate a protected write
    assign write_allowed = state_a & ~config_lock;

    // counter fields of the error status registers; upper bits stay live from the monitor
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            watchdog_failure_count       <= safety_cmd_pkg::reset_status[3:0];
            host_error_signal_fail_count <= safety_cmd_pkg::reset_status[3:0];
            device_error_count           <= safety_cmd_pkg::reset_status[3:0];
        end
        else if (cmd_valid && write_allowed)
        begin
            case (cmd_code)
                safety_cmd_pkg::cmd_wd_count_write:
                    watchdog_failure_count <= cmd_data[3:0];
                safety_cmd_pkg::cmd_host_esm_count_write:
                    host_error_signal_fail_count <= cmd_data[3:0];
                safety_cmd_pkg::cmd_dev_err_count_write:
                    device_error_count <= cmd_data[3:0];
                default:
                    watchdog_failure_count <= watchdog_failure_count;
            endcase
        end
    end

    // pulse-width limits, power-down threshold and expected crc
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            error_high_pulse_max <= safety_cmd_pkg::reset_setting;
            error_high_pulse_min <= safety_cmd_pkg::reset_setting;
            error_low_pulse_max  <= safety_cmd_pkg::reset_setting;
            error_low_pulse_min  <= safety_cmd_pkg::reset_setting;
            power_down_threshold <= safety_cmd_pkg::reset_setting;
            config_crc           <= safety_cmd_pkg::reset_setting;
        end
        else if (cmd_valid && write_allowed) // refused writes fall through
        begin
            case (cmd_code)
                safety_cmd_pkg::cmd_high_max_write:
                    error_high_pulse_max <= cmd_data;
                safety_cmd_pkg::cmd_high_min_write:
                    error_high_pulse_min <= cmd_data;
                safety_cmd_pkg::cmd_low_max_write:
                    error_low_pulse_max <= cmd_data;
                safety_cmd_pkg::cmd_low_min_write:
                    error_low_pulse_min <= cmd_data;
                safety_cmd_pkg::cmd_pwd_threshold_write:
                    power_down_threshold <= cmd_data;
                safety_cmd_pkg::cmd_config_crc_write:
                    config_crc <= cmd_data;
                default:
                    config_crc <= config_crc;
            endcase
        end
    end

    // self-test and check controls take effect regardless of lock or state
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            analog_selftest_control <= safety_cmd_pkg::reset_setting;
            logic_selftest_control  <= safety_cmd_pkg::reset_setting;
            safety_check_control    <= safety_cmd_pkg::reset_setting;
        end
        else if (cmd_valid)
        begin
            case (cmd_code)
                safety_cmd_pkg::cmd_analog_selftest_write:
                    analog_selftest_control <= cmd_data;
                safety_cmd_pkg::cmd_logic_selftest_write:
                    logic_selftest_control <= cmd_data;
                safety_cmd_pkg::cmd_safety_check_write:
                    safety_check_control <= cmd_data;
                default:
                    safety_check_control <= safety_check_control;
            endcase
        end
    end

    // write answer: one-cycle pulse, done or refused
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            write_done    <= 1'b0;
            write_refused <= 1'b0;
        end
        else
        begin
            write_done    <= cmd_valid &
                             (is_free_write | (is_protected_write & write_allowed));
            write_refused <= cmd_valid & is_protected_write & ~write_allowed;
        end
    end

    // read answer; counter sits in low nibble, monitor bits above
    // reads pass the value held before any write in the same cycle
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            read_valid   <= 1'b0;
            read_unknown <= 1'b0;
            read_data    <= safety_cmd_pkg::reset_read_data;
        end
        else
        begin
            read_valid   <= cmd_valid & is_known_read;
            read_unknown <= cmd_valid & ~is_known_read & ~is_protected_write & ~is_free_write;
            if (cmd_valid && is_known_read)
            begin
                case (cmd_code)
                    safety_cmd_pkg::cmd_status_two_read:
                        read_data <= {status_two_live[7:4], watchdog_failure_count};
                    safety_cmd_pkg::cmd_status_three_read:
                        read_data <= {status_three_live[7:4],
                                      host_error_signal_fail_count};
                    safety_cmd_pkg::cmd_status_four_read:
                        read_data <= {status_four_live[7:4], device_error_count};
                    safety_cmd_pkg::cmd_high_max_read:
                        read_data <= error_high_pulse_max;
                    safety_cmd_pkg::cmd_high_min_read:
                        read_data <= error_high_pulse_min;
                    safety_cmd_pkg::cmd_low_max_read:
                        read_data <= error_low_pulse_max;
                    safety_cmd_pkg::cmd_low_min_read:
                        read_data <= error_low_pulse_min;
                    safety_cmd_pkg::cmd_pwd_threshold_read:
                        read_data <= power_down_threshold;
                    safety_cmd_pkg::cmd_config_crc_read:
                        read_data <= config_crc;
                    safety_cmd_pkg::cmd_analog_selftest_read:
                        read_data <= analog_selftest_control;
                    safety_cmd_pkg::cmd_logic_selftest_read:
                        read_data <= logic_selftest_control;
                    safety_cmd_pkg::cmd_safety_check_read:
                        read_data <= safety_check_control;
                    default:
                        read_data <= safety_cmd_pkg::reset_read_data;
                endcase
            end
        end
    end

endmodule // spi_safety_command_decoder

// *** include/safety_cmd_pkg.sv ***
// holds command codes, reset values and field widths for the safety command decoder
// assumes the frame logic outside hands over one decoded command byte plus data per frame
package safety_cmd_pkg;

    localparam int  data_width          = 8;
    localparam int  count_width         = 4;

    // write codes of this slice
    localparam logic [7:0] cmd_wd_count_write      = 8'ha4;
    localparam logic [7:0] cmd_host_esm_count_write= 8'ha7;
    localparam logic [7:0] cmd_dev_err_count_write = 8'ha8;
    localparam logic [7:0] cmd_high_max_write      = 8'h91;
    localparam logic [7:0] cmd_high_min_write      = 8'h92;
    localparam logic [7:0] cmd_low_max_write       = 8'h94;
    localparam logic [7:0] cmd_low_min_write       = 8'h97;
    localparam logic [7:0] cmd_pwd_threshold_write = 8'h98;
    localparam logic [7:0] cmd_config_crc_write    = 8'h9b;
    localparam logic [7:0] cmd_analog_selftest_write = 8'hab;
    localparam logic [7:0] cmd_logic_selftest_write  = 8'had;
    localparam logic [7:0] cmd_safety_check_write    = 8'hae;

    // read codes of this slice
    localparam logic [7:0] cmd_status_two_read     = 8'h52;
    localparam logic [7:0] cmd_status_three_read   = 8'h54;
    localparam logic [7:0] cmd_status_four_read    = 8'h57;
    localparam logic [7:0] cmd_high_max_read       = 8'h61;
    localparam logic [7:0] cmd_high_min_read       = 8'h62;
    localparam logic [7:0] cmd_low_max_read        = 8'h64;
    localparam logic [7:0] cmd_low_min_read        = 8'h67;
    localparam logic [7:0] cmd_pwd_threshold_read  = 8'h68;
    localparam logic [7:0] cmd_config_crc_read     = 8'h6b;
    localparam logic [7:0] cmd_analog_selftest_read  = 8'h5b;
    localparam logic [7:0] cmd_logic_selftest_read   = 8'h5d;
    localparam logic [7:0] cmd_safety_check_read     = 8'h5e;

    // counter field position inside each error status register
    localparam int  count_lsb           = 0;

    // reset values
    localparam logic [7:0] reset_status    = 8'h00;
    localparam logic [7:0] reset_setting   = 8'h00;
    localparam logic [7:0] reset_read_data = 8'h00;

    // answer codes for a write
    typedef enum logic [1:0]
    {
        write_ok_type_none    = 2'h0,
        write_ok_type_done    = 2'h1,
        write_ok_type_refused = 2'h2
    } write_result_type;

endpackage

// *** tb/safety_cmd_chk.sv ***
// checker for the safety command decoder: write, refuse and read answers
// assumes it is bound to the decoder top and sees its ports by name
`timescale 1ns/1ps
module safety_cmd_chk
(
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_data,
    input wire logic       config_lock,
    input wire logic       state_a,
    input wire logic       read_valid,
    input wire logic [7:0] read_data,
    input wire logic       read_unknown,
    input wire logic       write_done,
    input wire logic       write_refused,
    input wire logic [3:0] watchdog_failure_count,
    input wire logic [7:0] error_high_pulse_max,
    input wire logic [7:0] config_crc
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // protected writes land only when unlocked and in state_a
    wire logic       open_ok  = !config_lock && state_a;
    wire logic [3:0] data_low = cmd_data[3:0];

    a_high_max_store: assert property (cmd_valid && cmd_code == 8'h91 && open_ok
        |=> write_done && error_high_pulse_max == $past(cmd_data)) else $error("high max lost");
    a_high_max_read: assert property (cmd_valid && cmd_code == 8'h61
        |=> read_valid && read_data == $past(error_high_pulse_max)) else $error("high max read");
    a_wd_count_store: assert property (cmd_valid && cmd_code == 8'ha4 && open_ok
        |=> watchdog_failure_count == $past(data_low)) else $error("wd count lost");
    a_wd_count_hold: assert property (cmd_valid && cmd_code == 8'ha4 && !open_ok
        |=> write_refused && $stable(watchdog_failure_count)) else $error("wd count changed");
    a_crc_store: assert property (cmd_valid && cmd_code == 8'h9b && open_ok
        |=> config_crc == $past(cmd_data)) else $error("crc lost");
    a_crc_refused_hold: assert property (cmd_valid && cmd_code == 8'h9b && !open_ok
        |=> !write_done && $stable(config_crc)) else $error("crc changed");
    a_free_write_done: assert property (cmd_valid && cmd_code inside {8'hab, 8'had, 8'hae}
        |=> write_done && !write_refused) else $error("free write refused");
    a_idle_quiet: assert property (!cmd_valid
        |=> !(read_valid || read_unknown || write_done || write_refused)) else $error("stray answer");
endmodule // safety_cmd_chk

bind spi_safety_command_decoder safety_cmd_chk chk_u
(
    .mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .config_lock(config_lock), .state_a(state_a),
    .read_valid(read_valid), .read_data(read_data), .read_unknown(read_unknown),
    .write_done(write_done), .write_refused(write_refused),
    .watchdog_failure_count(watchdog_failure_count),
    .error_high_pulse_max(error_high_pulse_max), .config_crc(config_crc)
);

// *** tb/safety_host_model.sv ***
// host controller model: one command per call, lock and state_a levels
// assumes the bench calls its tasks sequentially from one process
`timescale 1ns/1ps
module safety_host_model
(
    input  wire logic  mclk,
    output logic       cmd_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_data,
    output logic       config_lock,
    output logic       state_a
);
    // idle levels at time zero
    initial
    begin
        cmd_valid   = 1'b0;
        cmd_code    = 8'h00;
        cmd_data    = 8'h00;
        config_lock = 1'b0;
        state_a     = 1'b0;
    end

    // levels change on a falling edge, never during a command
    task automatic set_mode(input logic lock, input logic diag);
        @(negedge mclk);
        config_lock = lock;
        state_a     = diag;
    endtask

    // released bytes are inverted so a stale value never looks valid
    task automatic issue(input logic [7:0] code, input logic [7:0] data);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_code  = code;
        cmd_data  = data;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_code  = ~code;
        cmd_data  = ~data;
    endtask
endmodule // safety_host_model

// *** tb/tb_top.sv ***
// self-checking bench: every write code open, locked and outside state_a
// assumes answers stand in the cycle after the command edge
`timescale 1ns/1ps
module tb_top;
    logic       mclk, nrst, cmd_valid, config_lock, state_a;
    logic       read_valid, read_unknown, write_done, write_refused;
    logic [7:0] cmd_code, cmd_data, read_data, held;
    logic [3:0] cnt [3];
    logic [7:0] cfg [9];
    int         err_total = 0;
    int         n_checks  = 0;
    logic [7:0] live [3] = '{8'ha5, 8'hb6, 8'hc7};
    logic [7:0] wr_c [12] = '{8'ha4, 8'ha7, 8'ha8, 8'h91, 8'h92, 8'h94,
                              8'h97, 8'h98, 8'h9b, 8'hab, 8'had, 8'hae};
    logic [7:0] rd_c [12] = '{8'h52, 8'h54, 8'h57, 8'h61, 8'h62, 8'h64,
                              8'h67, 8'h68, 8'h6b, 8'h5b, 8'h5d, 8'h5e};

    spi_safety_command_decoder dut_u
    (
        .mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .config_lock(config_lock), .state_a(state_a),
        .status_two_live(live[0]), .status_three_live(live[1]), .status_four_live(live[2]),
        .read_valid(read_valid), .read_data(read_data), .read_unknown(read_unknown),
        .write_done(write_done), .write_refused(write_refused),
        .watchdog_failure_count(cnt[0]), .host_error_signal_fail_count(cnt[1]),
        .device_error_count(cnt[2]),
        .error_high_pulse_max(cfg[0]), .error_high_pulse_min(cfg[1]), .error_low_pulse_max(cfg[2]),
        .error_low_pulse_min(cfg[3]), .power_down_threshold(cfg[4]), .config_crc(cfg[5]),
        .analog_selftest_control(cfg[6]), .logic_selftest_control(cfg[7]),
        .safety_check_control(cfg[8])
    );

    safety_host_model host_u
    (
        .mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
        .config_lock(config_lock), .state_a(state_a)
    );

    // free-running 20 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // counters read back under the live upper nibble
    function automatic logic [7:0] expect_rd(input int i, input logic [7:0] d);
        return (i < 3) ? {live[i][7:4], d[3:0]} : d;
    endfunction

    // one write attempt, then a read of the same item
    task automatic attempt(input int i, input logic lock, input logic diag, input logic [7:0] d);
        logic takes;
        takes = (i > 8) || (!lock && diag);
        host_u.set_mode(lock, diag);
        host_u.issue(wr_c[i], d);
        check("write_done", {7'h0, write_done}, {7'h0, takes});
        check("write_refused", {7'h0, write_refused}, {7'h0, !takes});
        if (takes)
            held = d;
        // stored output seen directly, not only through the read path
        check("stored", (i < 3) ? {4'h0, cnt[i]} : cfg[i - 3],
              (i < 3) ? {4'h0, held[3:0]} : held); // to
        host_u.issue(rd_c[i], 8'h00);
        check("read_valid", {7'h0, read_valid}, 8'h01);
        check("read_data", read_data, expect_rd(i, held)); // to
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // whole sequence needs well under 200 us
    initial
    begin
        #200_000;
        err_total++;
        conclude();
    end

    initial
    begin
        nrst = 1'b0;
        repeat (16) @(negedge mclk);
        nrst = 1'b1;
        check("read_data", read_data, 8'h00);
        for (int i = 0; i < 12; i++)
        begin
            held = 8'h00;
            attempt(i, 1'b0, 1'b1, {4'h5, 4'(i)});
            attempt(i, 1'b1, 1'b1, {4'ha, ~4'(i)});
            attempt(i, 1'b0, 1'b0, {4'h3, 4'(i) ^ 4'h6});
        end
        host_u.issue(8'h9d, 8'h11);
        check("read_unknown", {7'h0, read_unknown}, 8'h01);
        // mid-run reset must clear a setting written earlier
        nrst = 1'b0;
        @(negedge mclk);
        nrst = 1'b1;
        check("stored", cfg[0], 8'h00);
        host_u.issue(8'h61, 8'h00);
        check("read_data", read_data, 8'h00);
        conclude();
    end
endmodule // tb_top
